// ---- design/dfrpc_defines.svh ----
// register offsets, field positions, reset values and command codes
// assumes byte addressing on a 32-bit AXI4-Lite register bus
`ifndef DFRPC_DEFINES_SVH
`define DFRPC_DEFINES_SVH
`define DFRPC_OFS_PTR 6'h00
`define DFRPC_OFS_WBUF 6'h04
`define DFRPC_OFS_RLO 6'h08
`define DFRPC_OFS_RHI 6'h0C
`define DFRPC_OFS_RMODE 6'h10
`define DFRPC_OFS_SEQ 6'h14
`define DFRPC_OFS_STAT 6'h18
`define DFRPC_RMODE_ON 7
`define DFRPC_RMODE_AR 1
`define DFRPC_RMODE_AI 0
`define DFRPC_SEQ_START 7
`define DFRPC_SEQ_MODE_HI 5
`define DFRPC_SEQ_MODE_LO 2
`define DFRPC_RST_PTR 16'h0000
`define DFRPC_RST_WBUF 32'h00000000
`define DFRPC_RST_RMODE 8'h00
`define DFRPC_RST_SEQ 8'h00
`define DFRPC_WORD_STEP 16'h0004
`define DFRPC_WORD_MASK 16'hFFFC
`define DFRPC_BLOCK_MASK 16'hF800
`define DFRPC_CMD_READ 4'h0
`define DFRPC_CMD_BLANK_BLK 4'h2
`define DFRPC_CMD_ERASE_BLK 4'h3
`define DFRPC_CMD_VERIFY_BLK 4'h6
`define DFRPC_RESP_OKAY 2'h0
`define DFRPC_RESP_SLVERR 2'h2
`endif

// ---- design/dfrpc_pkg.sv ----
// types shared by the data flash read/program controller
// assumes nothing beyond a SystemVerilog compiler
package dfrpc_pkg;
    // one-hot controller states
    typedef enum logic [4:0] {
        ST_OFF  = 5'h01,
        ST_IDLE = 5'h02,
        ST_READ = 5'h04,
        ST_PROG = 5'h08,
        ST_DONE = 5'h10
    } dfrpc_state_type;
endpackage : dfrpc_pkg

// ---- design/dfrpc_top.sv ----
// data flash read/program controller with an AXI4-Lite register slave
// assumes a flash macro that holds off done until it finishes a request
//
// Functional notes
// R1: flash holds 4-byte words in 2 KB blocks; erase works on blocks
// R2: software supplies address and starts each programming operation
// R3: auto read on: pointer write with changed address fetches a word
// R4: auto increment steps the pointer by four after each word
// R5: software reads low half first, high half completes the word
// R6: software writes 83H to enable auto read with increment
// R7: read mode register writes count only while in read mode; the flash on bit is also written while the flash is stopped
// R8: auto increment acts only when auto read is also selected
// R9: reads always return whole words, never single bytes
// R10: software starts the flash with the start routine after reset
// R11: software clears flash on before entering STOP
// R12: software clears flash on only in read mode
// R13: software loads pointer and write buffer, then sets start bit
// R14: end of programming raises the program end interrupt
// R15: programming never stalls the CPU or its bus
// R16: software sets only the start bit, never the mode field; here the command comes from the mode field written with start
// R17: software sets start only while no programming runs
// R18: software leaves controller registers alone while programming
// R19: software avoids STOP while the sequencer runs
// R20: program and data flash are never rewritten together
// R21: end routine returns the flash to read mode after programming
// R22: status and pass/fail of each operation are readable
// R23: mode 00 standby, 10 auto read, 11 with increment, 01 barred
// R24: after reset the flash is stopped with flash on at zero
// R25: start bit clears itself once the status check has finished
// R26: read buffer holds the word until the next auto read
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "dfrpc_defines.svh"
module dfrpc_top (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic NRST_IN,
    // axi4-lite write address and data
    input wire logic [31:0] AXI_AWADDR_IN,
    input wire logic AXI_AWVALID_IN,
    output logic AXI_AWREADY_OUT,
    input wire logic [31:0] AXI_WDATA_IN,
    input wire logic [3:0] AXI_WSTRB_IN,
    input wire logic AXI_WVALID_IN,
    output logic AXI_WREADY_OUT,
    // axi4-lite write response
    output logic [1:0] AXI_BRESP_OUT,
    output logic AXI_BVALID_OUT,
    input wire logic AXI_BREADY_IN,
    // axi4-lite read
    input wire logic [31:0] AXI_ARADDR_IN,
    input wire logic AXI_ARVALID_IN,
    output logic AXI_ARREADY_OUT,
    output logic [31:0] AXI_RDATA_OUT,
    output logic [1:0] AXI_RRESP_OUT,
    output logic AXI_RVALID_OUT,
    input wire logic AXI_RREADY_IN,
    // flash macro
    output logic FL_REQ_OUT,
    output logic [3:0] FL_CMD_OUT,
    output logic [15:0] FL_ADDR_OUT,
    output logic [31:0] FL_WDATA_OUT,
    input wire logic FL_DONE_IN,
    input wire logic FL_FAIL_IN,
    input wire logic [31:0] FL_RDATA_IN,
    // event to the system interrupt controller
    output logic PROG_END_IRQ_OUT
);
    // byte-lane merge used for every writable register
    function automatic logic [31:0] merge(input logic [31:0] old_v,
            input logic [31:0] new_v, input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    // register offsets that exist on the bus
    function automatic logic mapped(input logic [5:0] a);
        return a == `DFRPC_OFS_PTR || a == `DFRPC_OFS_WBUF ||
            a == `DFRPC_OFS_RLO || a == `DFRPC_OFS_RHI ||
            a == `DFRPC_OFS_RMODE || a == `DFRPC_OFS_SEQ ||
            a == `DFRPC_OFS_STAT;
    endfunction : mapped

    // bus state
    logic aw_v_r, aw_v_nxt, w_v_r, w_v_nxt;
    logic [5:0] aw_a_r, aw_a_nxt, ar_a;
    logic [31:0] w_d_r, w_d_nxt;
    logic [3:0] w_s_r, w_s_nxt;
    logic bv_r, bv_nxt, rv_r, rv_nxt;
    logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
    logic [31:0] rd_r, rd_nxt;
    logic wr_fire, rd_fire;
    // core state
    dfrpc_pkg::dfrpc_state_type st_r, st_nxt;
    logic [15:0] ptr_r, ptr_nxt;
    logic [31:0] wbuf_r, wbuf_nxt, rbuf_r, rbuf_nxt;
    logic flon_r, flon_nxt;
    logic [1:0] rsel_r, rsel_nxt;
    logic start_r, start_nxt;
    logic [3:0] smode_r, smode_nxt;
    logic fail_r, fail_nxt, done_r, done_nxt;
    logic req_r, req_nxt, irq_r, irq_nxt;
    logic [3:0] cmd_r, cmd_nxt;
    logic [15:0] fa_r, fa_nxt;
    logic auto_rd, auto_inc, rd_mode;
    logic [31:0] wv;
    logic [15:0] np;

    // stalls reach the master through ready; the core never waits on it
    assign wr_fire = aw_v_r && w_v_r && !bv_r; // R15
    assign rd_fire = AXI_ARVALID_IN && !rv_r;
    assign ar_a = AXI_ARADDR_IN[5:0];
    assign AXI_AWREADY_OUT = !aw_v_r;
    assign AXI_WREADY_OUT = !w_v_r;
    assign AXI_ARREADY_OUT = !rv_r;
    assign AXI_BVALID_OUT = bv_r;
    assign AXI_BRESP_OUT = br_r;
    assign AXI_RVALID_OUT = rv_r;
    assign AXI_RRESP_OUT = rr_r;
    assign AXI_RDATA_OUT = rd_r;

    // bus channel holding, response and read data mux
    always_comb begin
        aw_v_nxt = aw_v_r;
        aw_a_nxt = aw_a_r;
        w_v_nxt = w_v_r;
        w_d_nxt = w_d_r;
        w_s_nxt = w_s_r;
        bv_nxt = bv_r;
        br_nxt = br_r;
        rv_nxt = rv_r;
        rr_nxt = rr_r;
        rd_nxt = rd_r;
        if (AXI_AWVALID_IN && !aw_v_r) begin
            aw_v_nxt = 1'b1;
            aw_a_nxt = AXI_AWADDR_IN[5:0];
        end
        if (AXI_WVALID_IN && !w_v_r) begin
            w_v_nxt = 1'b1;
            w_d_nxt = AXI_WDATA_IN;
            w_s_nxt = AXI_WSTRB_IN;
        end
        if (bv_r && AXI_BREADY_IN) begin
            bv_nxt = 1'b0;
        end
        if (wr_fire) begin
            aw_v_nxt = 1'b0;
            w_v_nxt = 1'b0;
            bv_nxt = 1'b1;
            br_nxt = (mapped(aw_a_r) && aw_a_r[1:0] == 2'h0) ?
                `DFRPC_RESP_OKAY : `DFRPC_RESP_SLVERR;
        end
        if (rv_r && AXI_RREADY_IN) begin
            rv_nxt = 1'b0;
        end
        if (rd_fire) begin
            rv_nxt = 1'b1;
            rr_nxt = `DFRPC_RESP_OKAY;
            // whole halves only; bytes of the word are never split
            case (ar_a)
                `DFRPC_OFS_PTR: rd_nxt = {16'h0000, ptr_r};
                `DFRPC_OFS_WBUF: rd_nxt = wbuf_r;
                `DFRPC_OFS_RLO: rd_nxt = {16'h0000, rbuf_r[15:0]}; // R9
                `DFRPC_OFS_RHI: rd_nxt = {16'h0000, rbuf_r[31:16]}; // R9
                `DFRPC_OFS_RMODE:
                    rd_nxt = {24'h000000, flon_r, 5'h00, rsel_r};
                `DFRPC_OFS_SEQ:
                    rd_nxt = {24'h000000, start_r, 1'b0, smode_r, 2'h0};
                `DFRPC_OFS_STAT:
                    rd_nxt = {27'h0000000, st_r == dfrpc_pkg::ST_READ,
                        fail_r, done_r, st_r == dfrpc_pkg::ST_PROG,
                        flon_r}; // R22
                default: begin
                    rd_nxt = 32'h00000000;
                    rr_nxt = `DFRPC_RESP_SLVERR;
                end
            endcase
        end
    end

    // bus registers
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            aw_v_r <= 1'b0;
            aw_a_r <= 6'h00;
            w_v_r <= 1'b0;
            w_d_r <= 32'h00000000;
            w_s_r <= 4'h0;
            bv_r <= 1'b0;
            br_r <= 2'h0;
            rv_r <= 1'b0;
            rr_r <= 2'h0;
            rd_r <= 32'h00000000;
        end else begin
            aw_v_r <= aw_v_nxt;
            aw_a_r <= aw_a_nxt;
            w_v_r <= w_v_nxt;
            w_d_r <= w_d_nxt;
            w_s_r <= w_s_nxt;
            bv_r <= bv_nxt;
            br_r <= br_nxt;
            rv_r <= rv_nxt;
            rr_r <= rr_nxt;
            rd_r <= rd_nxt;
        end
    end

    // code 01 is barred and acts as standby
    assign auto_rd = rsel_r[`DFRPC_RMODE_AR]; // R23 R3
    assign auto_inc = auto_rd && rsel_r[`DFRPC_RMODE_AI]; // R8
    assign rd_mode = st_r == dfrpc_pkg::ST_IDLE ||
        st_r == dfrpc_pkg::ST_READ;
    assign FL_REQ_OUT = req_r;
    assign FL_CMD_OUT = cmd_r;
    assign FL_ADDR_OUT = fa_r;
    assign FL_WDATA_OUT = wbuf_r;
    assign PROG_END_IRQ_OUT = irq_r;

    // controller: register writes, flash requests, completions
    always_comb begin
        st_nxt = st_r;
        ptr_nxt = ptr_r;
        wbuf_nxt = wbuf_r;
        rbuf_nxt = rbuf_r;
        flon_nxt = flon_r;
        rsel_nxt = rsel_r;
        start_nxt = start_r;
        smode_nxt = smode_r;
        fail_nxt = fail_r;
        done_nxt = done_r;
        req_nxt = req_r;
        irq_nxt = 1'b0;
        cmd_nxt = cmd_r;
        fa_nxt = fa_r;
        wv = 32'h00000000;
        np = ptr_r;
        if (wr_fire) begin
            case (aw_a_r)
                `DFRPC_OFS_PTR: begin
                    wv = merge({16'h0000, ptr_r}, w_d_r, w_s_r);
                    np = wv[15:0] & `DFRPC_WORD_MASK; // R1
                    ptr_nxt = np;
                end
                `DFRPC_OFS_WBUF: wbuf_nxt = merge(wbuf_r, w_d_r, w_s_r);
                `DFRPC_OFS_RMODE: begin
                    wv = merge({24'h000000, flon_r, 5'h00, rsel_r},
                        w_d_r, w_s_r);
                    if (rd_mode) begin
                        rsel_nxt = wv[1:0]; // R7
                        flon_nxt = wv[`DFRPC_RMODE_ON];
                    end else if (st_r == dfrpc_pkg::ST_OFF) begin
                        flon_nxt = wv[`DFRPC_RMODE_ON]; // R7
                    end
                end
                `DFRPC_OFS_SEQ: begin
                    wv = merge({24'h000000, start_r, 1'b0, smode_r, 2'h0},
                        w_d_r, w_s_r);
                    // refused outside idle read mode: a run is never cut
                    if (st_r == dfrpc_pkg::ST_IDLE) begin
                        smode_nxt = wv[`DFRPC_SEQ_MODE_HI:
                            `DFRPC_SEQ_MODE_LO];
                        start_nxt = wv[`DFRPC_SEQ_START];
                    end
                end
                default: ;
            endcase
        end
        case (st_r)
            dfrpc_pkg::ST_OFF: begin
                if (flon_r) begin
                    st_nxt = dfrpc_pkg::ST_IDLE;
                end
            end
            dfrpc_pkg::ST_IDLE: begin
                if (!flon_r) begin
                    st_nxt = dfrpc_pkg::ST_OFF;
                end else if (start_r) begin
                    st_nxt = dfrpc_pkg::ST_PROG;
                    req_nxt = 1'b1;
                    done_nxt = 1'b0;
                    fail_nxt = 1'b0;
                    cmd_nxt = smode_r;
                    // block operations are sent block aligned
                    if (smode_r == `DFRPC_CMD_ERASE_BLK ||
                            smode_r == `DFRPC_CMD_BLANK_BLK ||
                            smode_r == `DFRPC_CMD_VERIFY_BLK) begin
                        fa_nxt = ptr_r & `DFRPC_BLOCK_MASK; // R1
                    end else begin
                        fa_nxt = ptr_r;
                    end
                end else if (wr_fire && aw_a_r == `DFRPC_OFS_PTR &&
                        np != ptr_r && auto_rd) begin
                    st_nxt = dfrpc_pkg::ST_READ; // R3
                    req_nxt = 1'b1;
                    cmd_nxt = `DFRPC_CMD_READ;
                    fa_nxt = np;
                end else if (rd_fire && ar_a == `DFRPC_OFS_RHI &&
                        auto_inc) begin
                    // high half ends the word: step and fetch the next
                    ptr_nxt = ptr_r + `DFRPC_WORD_STEP; // R4 R5
                    st_nxt = dfrpc_pkg::ST_READ;
                    req_nxt = 1'b1;
                    cmd_nxt = `DFRPC_CMD_READ;
                    fa_nxt = ptr_r + `DFRPC_WORD_STEP; // R4
                end
            end
            dfrpc_pkg::ST_READ: begin
                if (FL_DONE_IN) begin
                    req_nxt = 1'b0;
                    rbuf_nxt = FL_RDATA_IN; // R26 R9
                    st_nxt = dfrpc_pkg::ST_IDLE;
                end
            end
            dfrpc_pkg::ST_PROG: begin
                if (FL_DONE_IN) begin
                    req_nxt = 1'b0;
                    fail_nxt = FL_FAIL_IN; // R22
                    done_nxt = 1'b1;
                    irq_nxt = 1'b1; // R14
                    st_nxt = dfrpc_pkg::ST_DONE;
                end
            end
            dfrpc_pkg::ST_DONE: begin
                // reading status ends the check and frees the sequencer
                if (rd_fire && ar_a == `DFRPC_OFS_STAT) begin
                    start_nxt = 1'b0; // R25
                    st_nxt = dfrpc_pkg::ST_IDLE; // R21
                end
            end
            default: st_nxt = dfrpc_pkg::ST_OFF;
        endcase
    end

    // controller registers; flash comes up stopped
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            st_r <= dfrpc_pkg::ST_OFF; // R24
            ptr_r <= `DFRPC_RST_PTR;
            wbuf_r <= `DFRPC_RST_WBUF;
            rbuf_r <= 32'h00000000;
            flon_r <= 1'b0; // R24
            rsel_r <= 2'h0;
            start_r <= 1'b0;
            smode_r <= 4'h0;
            fail_r <= 1'b0;
            done_r <= 1'b0;
            req_r <= 1'b0;
            irq_r <= 1'b0;
            cmd_r <= 4'h0;
            fa_r <= 16'h0000;
        end else begin
            st_r <= st_nxt;
            ptr_r <= ptr_nxt;
            wbuf_r <= wbuf_nxt;
            rbuf_r <= rbuf_nxt;
            flon_r <= flon_nxt;
            rsel_r <= rsel_nxt;
            start_r <= start_nxt;
            smode_r <= smode_nxt;
            fail_r <= fail_nxt;
            done_r <= done_nxt;
            req_r <= req_nxt;
            irq_r <= irq_nxt;
            cmd_r <= cmd_nxt;
            fa_r <= fa_nxt;
        end
    end
endmodule : dfrpc_top
`default_nettype wire

// ---- verif/dfrpc_top_props.sv ----
// port checker for the data flash controller
// bound to dfrpc_top; sees only its ports
`timescale 1ns/1ns
`default_nettype none
module dfrpc_top_props (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic NRST_IN,
    // register bus
    input wire logic AXI_AWVALID_IN,
    input wire logic AXI_AWREADY_OUT,
    input wire logic AXI_WVALID_IN,
    input wire logic AXI_WREADY_OUT,
    input wire logic [1:0] AXI_BRESP_OUT,
    input wire logic AXI_BVALID_OUT,
    input wire logic AXI_BREADY_IN,
    input wire logic AXI_ARVALID_IN,
    input wire logic AXI_ARREADY_OUT,
    input wire logic [31:0] AXI_RDATA_OUT,
    input wire logic AXI_RVALID_OUT,
    input wire logic AXI_RREADY_IN,
    // flash link and event
    input wire logic FL_REQ_OUT,
    input wire logic [3:0] FL_CMD_OUT,
    input wire logic [15:0] FL_ADDR_OUT,
    input wire logic FL_DONE_IN,
    input wire logic PROG_END_IRQ_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!NRST_IN);
    // bus never stalls, even while programming runs
    write_lat_a:
    assert property (AXI_AWVALID_IN && AXI_AWREADY_OUT && AXI_WVALID_IN
        && AXI_WREADY_OUT |=> ##1 AXI_BVALID_OUT)
        else $error("no write answer");
    read_lat_a:
    assert property (AXI_ARVALID_IN && AXI_ARREADY_OUT |=> AXI_RVALID_OUT)
        else $error("no read answer");
    bresp_hold_a:
    assert property (AXI_BVALID_OUT && !AXI_BREADY_IN |=> AXI_BVALID_OUT
        && $stable(AXI_BRESP_OUT)) else $error("write answer dropped");
    rdata_hold_a:
    assert property (AXI_RVALID_OUT && !AXI_RREADY_IN |=> AXI_RVALID_OUT
        && $stable(AXI_RDATA_OUT)) else $error("read answer dropped");
    req_hold_a:
    assert property (FL_REQ_OUT && !FL_DONE_IN |=> FL_REQ_OUT
        && $stable(FL_ADDR_OUT) && $stable(FL_CMD_OUT))
        else $error("flash request moved");
    req_drop_a:
    assert property (FL_REQ_OUT && FL_DONE_IN |=> !FL_REQ_OUT)
        else $error("flash request kept");
    word_align_a:
    assert property (FL_REQ_OUT |-> FL_ADDR_OUT[1:0] == 2'h0)
        else $error("unaligned word");
    block_align_a:
    assert property (FL_REQ_OUT && FL_CMD_OUT inside {4'h2, 4'h3, 4'h6}
        |-> FL_ADDR_OUT[10:0] == 11'h000) else $error("unaligned block");
    irq_after_a:
    assert property (FL_REQ_OUT && FL_DONE_IN && FL_CMD_OUT != 4'h0
        |=> PROG_END_IRQ_OUT ##1 !PROG_END_IRQ_OUT) else $error("no end event");
    irq_cause_a:
    assert property (PROG_END_IRQ_OUT |-> $past(FL_REQ_OUT && FL_DONE_IN
        && FL_CMD_OUT != 4'h0)) else $error("stray end event");
    // main scenarios reached
    cover property (PROG_END_IRQ_OUT);
    cover property (FL_REQ_OUT && FL_DONE_IN && FL_CMD_OUT == 4'h0);
    cover property (AXI_BVALID_OUT && AXI_BRESP_OUT == 2'h2);
endmodule : dfrpc_top_props
bind dfrpc_top dfrpc_top_props dfrpc_top_props_i (.CLK_IN, .NRST_IN,
    .AXI_AWVALID_IN, .AXI_AWREADY_OUT, .AXI_WVALID_IN, .AXI_WREADY_OUT,
    .AXI_BRESP_OUT, .AXI_BVALID_OUT, .AXI_BREADY_IN, .AXI_ARVALID_IN,
    .AXI_ARREADY_OUT, .AXI_RDATA_OUT, .AXI_RVALID_OUT, .AXI_RREADY_IN,
    .FL_REQ_OUT, .FL_CMD_OUT, .FL_ADDR_OUT, .FL_DONE_IN, .PROG_END_IRQ_OUT);
`default_nettype wire

// ---- verif/dfrpc_flash_model.sv ----
// behavioural flash macro answering the controller
// assumes request held until the one-cycle done pulse
`timescale 1ns/1ns
`default_nettype none
module dfrpc_flash_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // request side
    input wire logic req_in,
    input wire logic [3:0] cmd_in,
    input wire logic [15:0] addr_in,
    input wire logic fail_mode_in,
    input wire logic slow_in,
    // answer side
    output logic done_out,
    output logic fail_out,
    output logic [31:0] rdata_out
);
    int cnt;
    // idle fail and data lines toggle so stale data never looks valid; done stays low
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt <= 0;
            done_out <= 1'b0;
            fail_out <= 1'b0;
            rdata_out <= 32'h00000000;
        end else begin
            done_out <= 1'b0;
            fail_out <= ~fail_out;
            rdata_out <= ~rdata_out;
            if (req_in && !done_out) begin
                cnt <= cnt + 1;
                if (cnt == (slow_in ? 10 : 1)) begin
                    cnt <= 0;
                    done_out <= 1'b1;
                    rdata_out <= {~addr_in, addr_in};
                    fail_out <= fail_mode_in && cmd_in != 4'h0;
                end
            end
        end
    end
endmodule : dfrpc_flash_model
`default_nettype wire

// ---- verif/test_data_flash_read_program_ctrl.sv ----
// bench for the data flash controller, acting as software
// assumes the flash model answers; word data is {~addr, addr}
`timescale 1ns/1ns
`default_nettype none
`include "dfrpc_defines.svh"
module test_data_flash_read_program_ctrl;
    logic CLK_IN, NRST_IN, AXI_AWVALID_IN, AXI_WVALID_IN, AXI_BREADY_IN;
    logic AXI_ARVALID_IN, AXI_RREADY_IN, FL_DONE_IN, FL_FAIL_IN;
    logic AXI_AWREADY_OUT, AXI_WREADY_OUT, AXI_BVALID_OUT, AXI_ARREADY_OUT;
    logic AXI_RVALID_OUT, FL_REQ_OUT, PROG_END_IRQ_OUT, fail_mode, slow;
    logic [31:0] AXI_AWADDR_IN, AXI_WDATA_IN, AXI_ARADDR_IN, AXI_RDATA_OUT;
    logic [31:0] FL_RDATA_IN, FL_WDATA_OUT, d;
    logic [3:0] AXI_WSTRB_IN, FL_CMD_OUT;
    logic [1:0] AXI_BRESP_OUT, AXI_RRESP_OUT, r;
    logic [15:0] FL_ADDR_OUT;
    logic [3:0] modes [4] = '{4'h2, 4'h3, 4'h6, 4'h4};
    int mismatches, tests_run, irqs, i;
    dfrpc_top dfrpc_top_i (.CLK_IN, .NRST_IN, .AXI_AWADDR_IN, .AXI_AWVALID_IN,
        .AXI_AWREADY_OUT, .AXI_WDATA_IN, .AXI_WSTRB_IN, .AXI_WVALID_IN,
        .AXI_WREADY_OUT, .AXI_BRESP_OUT, .AXI_BVALID_OUT, .AXI_BREADY_IN,
        .AXI_ARADDR_IN, .AXI_ARVALID_IN, .AXI_ARREADY_OUT, .AXI_RDATA_OUT,
        .AXI_RRESP_OUT, .AXI_RVALID_OUT, .AXI_RREADY_IN, .FL_REQ_OUT,
        .FL_CMD_OUT, .FL_ADDR_OUT, .FL_WDATA_OUT, .FL_DONE_IN, .FL_FAIL_IN,
        .FL_RDATA_IN, .PROG_END_IRQ_OUT);
    dfrpc_flash_model dfrpc_flash_model_i (.clk_in(CLK_IN), .nrst_in(NRST_IN),
        .req_in(FL_REQ_OUT), .cmd_in(FL_CMD_OUT), .addr_in(FL_ADDR_OUT),
        .fail_mode_in(fail_mode), .slow_in(slow), .done_out(FL_DONE_IN),
        .fail_out(FL_FAIL_IN), .rdata_out(FL_RDATA_IN));
    // 50 MHz clock
    initial begin
        CLK_IN = 1'b0;
        forever #10 CLK_IN = ~CLK_IN;
    end
    // count end-of-programming events
    always @(posedge CLK_IN) begin
        if (PROG_END_IRQ_OUT === 1'b1) irqs++;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // one write; payload held until each channel is taken
    task automatic wr(input logic [5:0] a, input logic [31:0] v);
        int n;
        @(posedge CLK_IN);
        AXI_AWADDR_IN <= {26'h0, a};
        AXI_WDATA_IN <= v;
        AXI_AWVALID_IN <= 1'b1;
        AXI_WVALID_IN <= 1'b1;
        AXI_BREADY_IN <= 1'b1;
        n = 0;
        do begin
            @(posedge CLK_IN);
            if (AXI_AWVALID_IN && AXI_AWREADY_OUT) AXI_AWVALID_IN <= 1'b0;
            if (AXI_WVALID_IN && AXI_WREADY_OUT) AXI_WVALID_IN <= 1'b0;
            n++;
        end while (AXI_BVALID_OUT !== 1'b1 && n < 50);
        if (AXI_BVALID_OUT !== 1'b1) mismatches++;
        r = AXI_BRESP_OUT;
        AXI_BREADY_IN <= 1'b0;
    endtask : wr
    task automatic rd(input logic [5:0] a);
        int n;
        @(posedge CLK_IN);
        AXI_ARADDR_IN <= {26'h0, a};
        AXI_ARVALID_IN <= 1'b1;
        AXI_RREADY_IN <= 1'b1;
        n = 0;
        do begin
            @(posedge CLK_IN);
            if (AXI_ARVALID_IN && AXI_ARREADY_OUT) AXI_ARVALID_IN <= 1'b0;
            n++;
        end while (AXI_RVALID_OUT !== 1'b1 && n < 50);
        if (AXI_RVALID_OUT !== 1'b1) mismatches++;
        d = AXI_RDATA_OUT;
        r = AXI_RRESP_OUT;
        AXI_RREADY_IN <= 1'b0;
    endtask : rd
    // poll status until the masked bits match; running out is a mismatch
    task automatic wait_stat(input logic [31:0] m, input logic [31:0] w);
        for (int k = 0; k < 40; k++) begin
            rd(`DFRPC_OFS_STAT);
            if ((d & m) === w) return;
        end
        mismatches++;
    endtask : wait_stat
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict
    // hang guard, far beyond the expected run
    initial begin
        #200000;
        mismatches++;
        print_verdict();
    end
    initial begin
        {NRST_IN, AXI_AWVALID_IN, AXI_WVALID_IN, AXI_BREADY_IN} = 4'h0;
        {AXI_ARVALID_IN, AXI_RREADY_IN, fail_mode} = 3'h0;
        {AXI_AWADDR_IN, AXI_WDATA_IN, AXI_ARADDR_IN} = 96'h0;
        AXI_WSTRB_IN = 4'hF;
        slow = 1'b1;
        {mismatches, tests_run, irqs} = 96'h0;
        repeat (5) @(posedge CLK_IN);
        NRST_IN <= 1'b1;
        rd(`DFRPC_OFS_RMODE); check(d, 32'h0);
        rd(`DFRPC_OFS_STAT); check(d, 32'h0);
        rd(6'h1C); check({30'h0, r}, {30'h0, `DFRPC_RESP_SLVERR});
        wr(`DFRPC_OFS_RMODE, 32'h03);
        rd(`DFRPC_OFS_RMODE); check(d, 32'h0);
        wr(`DFRPC_OFS_RMODE, 32'h80);
        wr(`DFRPC_OFS_RMODE, 32'h83);
        check({30'h0, r}, {30'h0, `DFRPC_RESP_OKAY});
        rd(`DFRPC_OFS_RMODE); check(d, 32'h83);
        // auto read with increment, buffer held during next fetch
        wr(`DFRPC_OFS_PTR, 32'h0100);
        wait_stat(32'h10, 32'h0);
        rd(`DFRPC_OFS_RLO); check(d, 32'h0100);
        rd(`DFRPC_OFS_RHI); check(d, 32'hFEFF);
        rd(`DFRPC_OFS_RLO); check(d, 32'h0100);
        wait_stat(32'h10, 32'h0);
        rd(`DFRPC_OFS_PTR); check(d, 32'h0104);
        rd(`DFRPC_OFS_RLO); check(d, 32'h0104);
        rd(`DFRPC_OFS_RHI); check(d, 32'hFEFB);
        wait_stat(32'h10, 32'h0);
        wr(`DFRPC_OFS_PTR, 32'h0108);
        rd(`DFRPC_OFS_STAT); check(d & 32'h10, 32'h0);
        // increment alone is standby; auto read alone keeps the pointer
        wr(`DFRPC_OFS_RMODE, 32'h81);
        wr(`DFRPC_OFS_PTR, 32'h0200);
        rd(`DFRPC_OFS_STAT); check(d & 32'h10, 32'h0);
        rd(`DFRPC_OFS_RHI);
        rd(`DFRPC_OFS_PTR); check(d, 32'h0200);
        slow <= 1'b0;
        wr(`DFRPC_OFS_RMODE, 32'h82);
        wr(`DFRPC_OFS_PTR, 32'h0300);
        wait_stat(32'h10, 32'h0);
        rd(`DFRPC_OFS_RHI); check(d, 32'hFCFF);
        rd(`DFRPC_OFS_PTR); check(d, 32'h0300);
        // block operations, then a word operation; the third one fails
        slow <= 1'b1;
        wr(`DFRPC_OFS_RMODE, 32'h80);
        for (i = 0; i < 4; i++) begin
            fail_mode <= (i == 2);
            wr(`DFRPC_OFS_PTR, 32'h0A04);
            wr(`DFRPC_OFS_WBUF, 32'hCAFE0000 | i);
            check(FL_WDATA_OUT, 32'hCAFE0000 | i);
            wr(`DFRPC_OFS_SEQ, 32'h80 | (modes[i] << 2));
            rd(`DFRPC_OFS_STAT); check(d & 32'h2, 32'h2);
            check({16'h0, FL_ADDR_OUT},
                (modes[i] == 4'h4) ? 32'h0A04 : 32'h0800);
            wait_stat(32'h4, 32'h4);
            check(d & 32'hE, {28'h0, fail_mode, 3'b100});
            check(irqs, i + 1);
            rd(`DFRPC_OFS_SEQ); check(d & 32'h80, 32'h0);
        end
        wr(`DFRPC_OFS_RMODE, 32'h00);
        rd(`DFRPC_OFS_STAT); check(d & 32'h1, 32'h0);
        print_verdict();
    end
endmodule : test_data_flash_read_program_ctrl
`default_nettype wire
